//--- hdl/irq_ctrl_top.sv
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_params.svh"
module irq_ctrl_top
  import irq_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic ext_request_pin0,
  input wire logic ext_request_pin1,
  input wire logic timer0_req,
  input wire logic timer1_req,
  input wire logic timer2_req,
  input wire logic serial_req,
  input wire logic spi_req,
  input wire logic keyboard_req,
  input wire logic counter_array_req,
  output logic core_irq_req,
  output logic [3:0] core_irq_id,
  output logic [1:0] core_irq_level,
  input wire logic core_irq_ack,
  input wire logic core_irq_return,
  output logic event_irq,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  irq_arb_if arb_link ();

  irq_arbiter u_arbiter (
    .arb(arb_link.arb)
  );

  // Shared address decode for the read and write paths.
  function automatic reg_sel_e decode(input logic [`ADDR_W-1:0] addr);
    case (addr)
      `BYTE_ADDR(`IDX_ENABLE_PRI): decode = SEL_ENABLE_PRI; // R9
      `BYTE_ADDR(`IDX_PRIO_HIGH_PRI): decode = SEL_PRIO_HIGH_PRI; // R13
      `BYTE_ADDR(`IDX_PRIO_LOW_PRI): decode = SEL_PRIO_LOW_PRI; // R11
      `BYTE_ADDR(`IDX_ENABLE_SEC): decode = SEL_ENABLE_SEC; // R15
      `BYTE_ADDR(`IDX_PRIO_LOW_SEC): decode = SEL_PRIO_LOW_SEC; // R16
      `BYTE_ADDR(`IDX_PRIO_HIGH_SEC): decode = SEL_PRIO_HIGH_SEC; // R16
      `BYTE_ADDR(`IDX_EVENT_STATUS): decode = SEL_EVENT_STATUS;
      `BYTE_ADDR(`IDX_EVENT_CLEAR): decode = SEL_EVENT_CLEAR;
      `BYTE_ADDR(`IDX_EVENT_ENABLE): decode = SEL_EVENT_ENABLE;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // The two pins come from outside the clock domain and pass two flops first.
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      pin_meta_reg <= {ext_request_pin1, ext_request_pin0};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Requests gathered by source number.
  src_vec_t raw_req;
  assign raw_req = {spi_req, keyboard_req, counter_array_req, timer2_req, serial_req,
                    timer1_req, pin_sync_reg[1], timer0_req, pin_sync_reg[0]}; // R1

  // Register state.
  logic [7:0] enable_pri_reg;
  logic [7:0] enable_pri_next;
  logic [6:0] prio_high_pri_reg;
  logic [6:0] prio_high_pri_next;
  logic [6:0] prio_low_pri_reg;
  logic [6:0] prio_low_pri_next;
  logic [1:0] enable_sec_reg;
  logic [1:0] enable_sec_next;
  logic [1:0] prio_low_sec_reg;
  logic [1:0] prio_low_sec_next;
  logic [1:0] prio_high_sec_reg;
  logic [1:0] prio_high_sec_next;
  src_vec_t event_status_reg;
  src_vec_t event_status_next;
  src_vec_t event_enable_reg;
  src_vec_t event_enable_next;
  src_vec_t req_prev_reg;
  logic event_irq_next;

  // Bus state.
  wr_state_e wr_state_reg;
  wr_state_e wr_state_next;
  rd_state_e rd_state_reg;
  rd_state_e rd_state_next;
  logic aw_have_reg;
  logic aw_have_next;
  logic w_have_reg;
  logic w_have_next;
  logic [`ADDR_W-1:0] aw_addr_reg;
  logic [`ADDR_W-1:0] aw_addr_next;
  logic [7:0] w_byte_reg;
  logic [7:0] w_byte_next;
  logic w_lane_reg;
  logic w_lane_next;
  logic [1:0] bresp_next;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;
  logic do_write;

  assign wr_sel = decode(aw_addr_reg);
  assign rd_sel = decode(s_axi_araddr);
  assign do_write = (wr_state_reg == WR_COLLECT) && aw_have_reg && w_have_reg;

  // Write channel: address and data are taken in either order, then one response.
  always_comb
  begin
    wr_state_next = wr_state_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    aw_addr_next = aw_addr_reg;
    w_byte_next = w_byte_reg;
    w_lane_next = w_lane_reg;
    bresp_next = s_axi_bresp;
    case (wr_state_reg)
      WR_COLLECT:
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_have_next = 1'b1;
          aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_have_next = 1'b1;
          w_byte_next = s_axi_wdata[7:0];
          w_lane_next = s_axi_wstrb[0];
        end
        if (do_write)
        begin
          aw_have_next = 1'b0;
          w_have_next = 1'b0;
          bresp_next = (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
          wr_state_next = WR_RESPOND;
        end
      end
      WR_RESPOND:
      begin
        if (s_axi_bready)
        begin
          wr_state_next = WR_COLLECT;
        end
      end
      default: wr_state_next = WR_COLLECT;
    endcase
  end

  // Read channel: data is looked up when the address is taken.
  always_comb
  begin
    rd_state_next = rd_state_reg;
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    case (rd_state_reg)
      RD_IDLE:
      begin
        if (s_axi_arvalid && s_axi_arready)
        begin
          rd_state_next = RD_RESPOND;
          rresp_next = (rd_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
          case (rd_sel)
            SEL_ENABLE_PRI: rdata_next = {24'h0, enable_pri_reg};
            SEL_PRIO_HIGH_PRI: rdata_next = {25'h0, prio_high_pri_reg}; // R14
            SEL_PRIO_LOW_PRI: rdata_next = {25'h0, prio_low_pri_reg};
            SEL_ENABLE_SEC: rdata_next = {29'h0, enable_sec_reg[1], 1'b0, enable_sec_reg[0]};
            SEL_PRIO_LOW_SEC: rdata_next = {29'h0, prio_low_sec_reg[1], 1'b0,
                                            prio_low_sec_reg[0]};
            SEL_PRIO_HIGH_SEC: rdata_next = {29'h0, prio_high_sec_reg[1], 1'b0,
                                             prio_high_sec_reg[0]};
            SEL_EVENT_STATUS: rdata_next = {23'h0, event_status_reg};
            SEL_EVENT_ENABLE: rdata_next = {23'h0, event_enable_reg};
            default: rdata_next = 32'h0;
          endcase
        end
      end
      RD_RESPOND:
      begin
        if (s_axi_rready)
        begin
          rd_state_next = RD_IDLE;
        end
      end
      default: rd_state_next = RD_IDLE;
    endcase
  end

  // Register writes; only byte lane 0 carries bits, other lanes are ignored.
  always_comb
  begin
    enable_pri_next = enable_pri_reg;
    prio_high_pri_next = prio_high_pri_reg;
    prio_low_pri_next = prio_low_pri_reg;
    enable_sec_next = enable_sec_reg;
    prio_low_sec_next = prio_low_sec_reg;
    prio_high_sec_next = prio_high_sec_reg;
    event_enable_next = event_enable_reg;
    if (do_write && w_lane_reg)
    begin
      case (wr_sel)
        SEL_ENABLE_PRI: enable_pri_next = w_byte_reg; // R9
        SEL_PRIO_HIGH_PRI: prio_high_pri_next = w_byte_reg[6:0]; // R13 R14
        SEL_PRIO_LOW_PRI: prio_low_pri_next = w_byte_reg[6:0]; // R11 R14
        SEL_ENABLE_SEC: enable_sec_next = {w_byte_reg[`BIT_SEC_SPI], w_byte_reg[`BIT_SEC_KBD]};
        SEL_PRIO_LOW_SEC: prio_low_sec_next = {w_byte_reg[`BIT_SEC_SPI],
                                               w_byte_reg[`BIT_SEC_KBD]}; // R16
        SEL_PRIO_HIGH_SEC: prio_high_sec_next = {w_byte_reg[`BIT_SEC_SPI],
                                                 w_byte_reg[`BIT_SEC_KBD]}; // R16
        SEL_EVENT_ENABLE: event_enable_next = {w_byte_reg[0], w_byte_reg};
        default: enable_pri_next = enable_pri_reg;
      endcase
    end
  end

  // Event flags: a rising request sets its flag; a new edge beats a clear.
  src_vec_t clear_mask;
  always_comb
  begin
    clear_mask = 9'h000;
    if (do_write && w_lane_reg && (wr_sel == SEL_EVENT_CLEAR))
    begin
      clear_mask = {1'b0, w_byte_reg};
    end
    event_status_next = (event_status_reg & ~clear_mask) | (raw_req & ~req_prev_reg);
    event_irq_next = |(event_status_next & event_enable_next);
  end

  // Forwarding to the arbiter: individual enables under the global enable.
  src_vec_t src_enable;
  assign src_enable = {enable_sec_reg[1], enable_sec_reg[0], enable_pri_reg[6:0]}; // R2 R15
  assign arb_link.pending = raw_req & src_enable & {`NUM_SRC{enable_pri_reg[`BIT_GLOBAL_EN]}}; // R3
  assign arb_link.prio_high = {prio_high_sec_reg, prio_high_pri_reg};
  assign arb_link.prio_low = {prio_low_sec_reg, prio_low_pri_reg};

  // Nesting: one in-service flag per level; return ends the innermost service.
  logic [3:0] in_service_reg;
  logic [3:0] in_service_next;
  logic core_irq_req_next;
  assign arb_link.in_service = in_service_reg;
  always_comb
  begin
    in_service_next = in_service_reg;
    if (core_irq_return)
    begin
      for (int l = 0; l < 4; l++)
      begin
        if (in_service_reg[l] && ((in_service_reg >> (l + 1)) == 4'h0))
        begin
          in_service_next[l] = 1'b0;
        end
      end
    end
    if (core_irq_ack && core_irq_req)
    begin
      in_service_next[core_irq_level] = 1'b1; // R5
    end
    core_irq_req_next = arb_link.grant_valid && !(core_irq_ack && core_irq_req);
  end

  // All state except the pin synchronisers is registered here; clk_en freezes everything.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      enable_pri_reg <= `RST_ENABLE_PRI; // R10
      prio_high_pri_reg <= `RST_PRIO_PRI;
      prio_low_pri_reg <= `RST_PRIO_PRI; // R12
      enable_sec_reg <= `RST_SEC;
      prio_low_sec_reg <= `RST_SEC;
      prio_high_sec_reg <= `RST_SEC;
      event_status_reg <= `RST_EVENTS;
      event_enable_reg <= `RST_EVENTS;
      req_prev_reg <= `RST_EVENTS;
      event_irq <= 1'b0;
      in_service_reg <= 4'h0;
      core_irq_req <= 1'b0;
      core_irq_id <= 4'h0;
      core_irq_level <= 2'h0;
      wr_state_reg <= WR_COLLECT;
      rd_state_reg <= RD_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_byte_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (clk_en)
    begin
      enable_pri_reg <= enable_pri_next;
      prio_high_pri_reg <= prio_high_pri_next;
      prio_low_pri_reg <= prio_low_pri_next;
      enable_sec_reg <= enable_sec_next;
      prio_low_sec_reg <= prio_low_sec_next;
      prio_high_sec_reg <= prio_high_sec_next;
      event_status_reg <= event_status_next;
      event_enable_reg <= event_enable_next;
      req_prev_reg <= raw_req;
      event_irq <= event_irq_next;
      in_service_reg <= in_service_next;
      core_irq_req <= core_irq_req_next;
      core_irq_id <= arb_link.grant_id; // R8
      core_irq_level <= arb_link.grant_level; // R7
      wr_state_reg <= wr_state_next;
      rd_state_reg <= rd_state_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      aw_addr_reg <= aw_addr_next;
      w_byte_reg <= w_byte_next;
      w_lane_reg <= w_lane_next;
      s_axi_awready <= (wr_state_next == WR_COLLECT) && !aw_have_next;
      s_axi_wready <= (wr_state_next == WR_COLLECT) && !w_have_next;
      s_axi_bvalid <= (wr_state_next == WR_RESPOND);
      s_axi_bresp <= bresp_next;
      s_axi_arready <= (rd_state_next == RD_IDLE);
      s_axi_rvalid <= (rd_state_next == RD_RESPOND);
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
    end
  end
endmodule
`default_nettype wire

//--- hdl/irq_ctrl_params.svh
// How it works
// R1 - Nine request sources, each with own vector.
// R2 - Per-source enable bit gates forwarding to core.
// R3 - Global enable bit 7 blocks everything when zero; event flags and event_irq are not gated by it.
// R4 - Level equals high bit over low bit.
// R5 - Preemption only by strictly higher level request.
// R6 - Highest level service is never preempted.
// R7 - Simultaneous requests: higher level wins.
// R8 - Equal level: fixed polling order decides.
// R9 - Primary enable register layout at A8h.
// R10 - Primary enable resets to zero.
// R11 - Primary low priority register at B8h.
// R12 - Low priority bits six to zero reset clear.
// R13 - Primary high priority register at B7h.
// R14 - Software never writes priority bit seven.
// R15 - Secondary enable at B1h, SPI bit2, keyboard bit0.
// R16 - Secondary priority low B2h, high B3h.
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH

`define NUM_SRC 9
`define ADDR_W 12

// Printed register indices; byte address is four times the index.
`define IDX_ENABLE_PRI 8'hA8
`define IDX_PRIO_HIGH_PRI 8'hB7
`define IDX_PRIO_LOW_PRI 8'hB8
`define IDX_ENABLE_SEC 8'hB1
`define IDX_PRIO_LOW_SEC 8'hB2
`define IDX_PRIO_HIGH_SEC 8'hB3
`define IDX_EVENT_STATUS 8'hC0
`define IDX_EVENT_CLEAR 8'hC1
`define IDX_EVENT_ENABLE 8'hC2
`define BYTE_ADDR(idx) ({2'h0, idx, 2'h0})

// Field positions.
`define BIT_GLOBAL_EN 7
`define BIT_SEC_SPI 2
`define BIT_SEC_KBD 0
`define PRI_FIELD_W 7

// Reset values.
`define RST_ENABLE_PRI 8'h00
`define RST_PRIO_PRI 7'h00
`define RST_SEC 2'h0
`define RST_EVENTS 9'h000

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- hdl/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  typedef logic [1:0] level_t;
  typedef logic [3:0] src_id_t;
  typedef logic [8:0] src_vec_t;

  // Source numbering; the number is also the polling rank within a level.
  typedef enum logic [3:0] {
    SRC_EXT0, SRC_TIMER0, SRC_EXT1, SRC_TIMER1, SRC_SERIAL,
    SRC_TIMER2, SRC_COUNTER_ARRAY, SRC_KEYBOARD, SRC_SPI
  } src_e;

  typedef enum {
    SEL_NONE, SEL_ENABLE_PRI, SEL_PRIO_HIGH_PRI, SEL_PRIO_LOW_PRI, SEL_ENABLE_SEC,
    SEL_PRIO_LOW_SEC, SEL_PRIO_HIGH_SEC, SEL_EVENT_STATUS, SEL_EVENT_CLEAR,
    SEL_EVENT_ENABLE
  } reg_sel_e;

  typedef enum {WR_COLLECT, WR_RESPOND} wr_state_e;
  typedef enum {RD_IDLE, RD_RESPOND} rd_state_e;
endpackage

//--- hdl/irq_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface irq_arb_if;
  import irq_ctrl_pkg::*;
  src_vec_t pending;
  src_vec_t prio_high;
  src_vec_t prio_low;
  logic [3:0] in_service;
  logic grant_valid;
  src_id_t grant_id;
  level_t grant_level;

  modport ctrl (output pending, prio_high, prio_low, in_service,
                input grant_valid, grant_id, grant_level);
  modport arb (input pending, prio_high, prio_low, in_service,
               output grant_valid, grant_id, grant_level);
endinterface
`default_nettype wire

//--- hdl/irq_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter
  import irq_ctrl_pkg::*;
(
  irq_arb_if.arb arb
);
  level_t src_level [`NUM_SRC];
  level_t best_level;
  src_id_t best_id;
  logic best_found;
  logic [2:0] service_floor;

  // Each source level is its high bit over its low bit.
  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g++)
    begin : gen_level
      assign src_level[g] = {arb.prio_high[g], arb.prio_low[g]}; // R4
    end
  endgenerate

  // Scan from the last source down so that a lower index wins a tie.
  always_comb
  begin
    best_level = 2'h0;
    best_id = 4'h0;
    best_found = 1'b0;
    for (int i = `NUM_SRC - 1; i >= 0; i--)
    begin
      if (arb.pending[i] && (!best_found || src_level[i] >= best_level)) // R7 R8
      begin
        best_level = src_level[i];
        best_id = 4'(i);
        best_found = 1'b1;
      end
    end
  end

  // One above the highest level in service; zero when idle.
  always_comb
  begin
    service_floor = 3'h0;
    for (int l = 0; l < 4; l++)
    begin
      if (arb.in_service[l])
      begin
        service_floor = 3'(l + 1);
      end
    end
  end

  // Only a strictly higher level may interrupt; nothing exceeds level 3.
  assign arb.grant_valid = best_found && ({1'b0, best_level} >= service_floor); // R5 R6
  assign arb.grant_id = best_id;
  assign arb.grant_level = best_level;
endmodule
`default_nettype wire

//--- verif/irq_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic timer0_req,
  input wire logic timer1_req,
  input wire logic timer2_req,
  input wire logic serial_req,
  input wire logic spi_req,
  input wire logic keyboard_req,
  input wire logic counter_array_req,
  input wire logic core_irq_req,
  input wire logic [3:0] core_irq_id,
  input wire logic [1:0] core_irq_level,
  input wire logic core_irq_ack,
  input wire logic core_irq_return,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [3:0] svc_reg, svc_next, top_bit;
  logic [8:0] live, live_reg;

  // Levels under service, nested the way the core does; return drops the innermost one.
  always_comb
  begin
    top_bit = svc_reg[3] ? 4'h8 : svc_reg[2] ? 4'h4 : svc_reg[1] ? 4'h2 : {3'h0, svc_reg[0]};
    svc_next = core_irq_return ? (svc_reg & ~top_bit) : svc_reg;
    if (core_irq_ack && core_irq_req)
      svc_next[core_irq_level] = 1'b1;
  end

  // Synchronised pins lag and are not tracked, so they count as live.
  assign live = {spi_req, keyboard_req, counter_array_req, timer2_req, serial_req, timer1_req,
    1'b1, timer0_req, 1'b1};

  // Frozen clock enable freezes the tracking as it freezes the design.
  always_ff @(posedge core_clk)
  begin
    if (clk_en)
      live_reg <= live;
    if (reset)
      svc_reg <= 4'h0;
    else if (clk_en)
      svc_reg <= svc_next;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset || !clk_en);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence offer_taken;
    core_irq_req && core_irq_ack;
  endsequence

  AST_ACK_DROP: assert property (offer_taken |=> !core_irq_req)
    else $error("offer still raised after the core took it");
  AST_NEST_LEVEL: assert property (core_irq_req |-> (svc_reg >> core_irq_level) == 4'h0)
    else $error("offer level not above every level in service");
  AST_TOP_BLOCKS: assert property (svc_reg[3] && !core_irq_return |=> !core_irq_req)
    else $error("offer made while the top level is in service");
  AST_ID_RANGE: assert property (core_irq_req |-> core_irq_id <= 4'h8)
    else $error("offered source number out of range");
  AST_SRC_LIVE: assert property (core_irq_req |-> live_reg[core_irq_id])
    else $error("offered source had no request");
  AST_WR_LAT: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after the write was taken");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response withdrawn or changed before acceptance");
  AST_RD_LAT: assert property (rd_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after the address was taken");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data withdrawn or changed before acceptance");
endmodule

bind irq_ctrl_top irq_ctrl_asserts chk (.*);
`default_nettype wire

//--- verif/irq_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_core_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic core_irq_req,
  input wire logic [3:0] core_irq_id,
  input wire logic [1:0] core_irq_level,
  input wire logic auto_ack,
  input wire logic [1:0] ack_dly,
  input wire logic ret_cmd,
  output logic core_irq_ack,
  output logic core_irq_return,
  output logic [3:0] last_id,
  output logic [7:0] acks
);
  logic [1:0] wait_cnt = 2'h0;

  // Acks come after a chosen delay, to cover slow vectoring.
  always @(posedge core_clk)
  begin
    core_irq_ack <= 1'b0;
    core_irq_return <= ret_cmd && !reset;
    if (reset)
    begin
      wait_cnt <= 2'h0;
      acks <= 8'h00;
      last_id <= 4'h0;
    end
    else
    begin
      if (core_irq_ack && core_irq_req)
      begin
        last_id <= core_irq_id;
        acks <= acks + 8'h01;
      end
      if (core_irq_req && auto_ack && !core_irq_ack)
      begin
        wait_cnt <= wait_cnt + 2'h1;
        if (wait_cnt == ack_dly)
          core_irq_ack <= 1'b1;
      end
      else
        wait_cnt <= 2'h0;
    end
  end
endmodule
`default_nettype wire

//--- verif/nine_source_four_level_irq_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_params.svh"
module nine_source_four_level_irq_ctrl_tb;
  localparam A_EN = `BYTE_ADDR(`IDX_ENABLE_PRI);
  localparam A_PH = `BYTE_ADDR(`IDX_PRIO_HIGH_PRI);
  localparam A_PL = `BYTE_ADDR(`IDX_PRIO_LOW_PRI);
  localparam A_EN2 = `BYTE_ADDR(`IDX_ENABLE_SEC);
  localparam A_PL2 = `BYTE_ADDR(`IDX_PRIO_LOW_SEC);
  localparam A_PH2 = `BYTE_ADDR(`IDX_PRIO_HIGH_SEC);
  localparam A_ST = `BYTE_ADDR(`IDX_EVENT_STATUS);
  localparam A_CLR = `BYTE_ADDR(`IDX_EVENT_CLEAR);
  localparam A_EVE = `BYTE_ADDR(`IDX_EVENT_ENABLE);
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [8:0] req_v = 9'h000;
  logic auto_ack = 1'b0, ret_cmd = 1'b0;
  logic [1:0] ack_dly = 2'h0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, core_irq_level;
  logic [31:0] s_axi_rdata;
  logic core_irq_req, core_irq_ack, core_irq_return, event_irq;
  logic [3:0] core_irq_id, last_id;
  logic [7:0] acks;
  int failures = 0, checked = 0, cycles = 0;
  // Register table walk and the nesting script; priority bit 7 is never written.
  logic [11:0] raddr[7] = '{A_EN, A_PH, A_PL, A_EN2, A_PL2, A_PH2, A_EVE};
  logic [7:0] rmask[7] = '{8'hFF, 8'h7F, 8'h7F, 8'h05, 8'h05, 8'h05, 8'hFE};
  logic [8:0] nq[6] = '{9'h002, 9'h012, 9'h01A, 9'h03A, 9'h01A, 9'h01A};
  logic [7:0] na[6] = '{8'h01, 8'h02, 8'h02, 8'h03, 8'h03, 8'h04};
  logic [3:0] ni[6] = '{4'h1, 4'h4, 4'h4, 4'h5, 4'h5, 4'h3};

  // Free-running core clock.
  initial forever #5 core_clk = ~core_clk;

  irq_ctrl_top dut (.*, .clk_en(1'b1), .s_axi_wstrb(4'hF),
    .ext_request_pin0(req_v[0]), .timer0_req(req_v[1]), .ext_request_pin1(req_v[2]),
    .timer1_req(req_v[3]), .serial_req(req_v[4]), .timer2_req(req_v[5]),
    .counter_array_req(req_v[6]), .keyboard_req(req_v[7]), .spi_req(req_v[8]));

  irq_core_model core (.*);

  task automatic end_of_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic sreq(input logic [8:0] v);
    @(posedge core_clk);
    req_v <= v;
  endtask

  task automatic pulse_ret;
    @(posedge core_clk);
    ret_cmd <= 1'b1;
    @(posedge core_clk);
    ret_cmd <= 1'b0;
  endtask

  // Address and data go out together; each is dropped on its own once taken.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        chk("bresp", er, s_axi_bresp);
      if (s_axi_bvalid)
        s_axi_bready <= 1'b0;
    end
    while (s_axi_awvalid || s_axi_wvalid || s_axi_bready);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what,
      input logic [1:0] er = `RESP_OKAY);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        chk(what, exp, s_axi_rdata);
        chk("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'b0;
      end
    end
    while (s_axi_arvalid || s_axi_rready);
  endtask

  // Spreads per-source vectors over the registers.
  task automatic prog(input logic g, input logic [8:0] en, input logic [8:0] hi,
      input logic [8:0] lo);
    wr(A_EN, {24'h0, g, en[6:0]});
    wr(A_PH, {25'h0, hi[6:0]});
    wr(A_PL, {25'h0, lo[6:0]});
    wr(A_EN2, {29'h0, en[8], 1'b0, en[7]});
    wr(A_PL2, {29'h0, lo[8], 1'b0, lo[7]});
    wr(A_PH2, {29'h0, hi[8], 1'b0, hi[7]});
  endtask

  // Offer expected with nothing in service; a tie goes to the lower number.
  function automatic logic [6:0] win(input logic [8:0] rq, input logic [8:0] en,
      input logic [8:0] hi, input logic [8:0] lo, input logic g);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 0; i < 9; i++)
      if (g && rq[i] && en[i] && (!r[6] || {hi[i], lo[i]} > r[5:4]))
        r = {1'b1, hi[i], lo[i], 4'(i)};
    return r;
  endfunction

  task automatic do_reset;
    @(posedge core_clk);
    reset <= 1'b1;
    cyc(16);
    reset <= 1'b0;
    rd(A_EN, 32'h0, "enable_pri");
    rd(A_PL, 32'h0, "prio_low_pri");
    rd(A_PH, 32'h0, "prio_high_pri");
    rd(A_EN2, 32'h0, "enable_sec");
    rd(A_PL2, 32'h0, "prio_low_sec");
    rd(A_PH2, 32'h0, "prio_high_sec");
    rd(A_ST, 32'h0, "event_status");
    $display("reset test done");
  endtask

  // A hang ends the run as a mismatch.
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  initial
  begin
    logic [8:0] en, hi, lo, rq;
    logic g;
    logic [6:0] w;
    logic [31:0] d;
    void'($urandom(22));
    do_reset();
    rd(12'h010, 32'h0, "unmapped", `RESP_SLVERR);
    wr(12'h010, 32'hFF, `RESP_SLVERR);
    for (int i = 0; i < 7; i++)
    begin
      d = $urandom & {24'h0, rmask[i]};
      wr(raddr[i], d);
      rd(raddr[i], d, "reg_rw");
    end
    $display("register test done");
    for (int i = 0; i < 24; i++)
    begin
      g = (i == 0) ? 1'b0 : 1'($urandom);
      en = (i == 0) ? 9'h1FF : 9'($urandom);
      hi = 9'($urandom);
      lo = 9'($urandom);
      rq = (i == 0) ? 9'h1FF : 9'($urandom);
      prog(g, en, hi, lo);
      sreq(rq);
      cyc(5);
      w = win(rq, en, hi, lo, g);
      chk("irq_req", w[6], core_irq_req);
      if (w[6])
      begin
        chk("irq_id", w[3:0], core_irq_id);
        chk("irq_level", w[5:4], core_irq_level);
      end
    end
    sreq(9'h000);
    $display("arbitration test done");
    prog(1'b1, 9'h1FF, 9'h038, 9'h020);
    ack_dly <= 2'($urandom);
    auto_ack <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      sreq(nq[i]);
      if (i > 3)
        pulse_ret();
      cyc(10);
      chk("ack_count", na[i], acks);
      chk("acked_id", ni[i], last_id);
      chk("irq_req_held", 32'h0, core_irq_req);
    end
    auto_ack <= 1'b0;
    sreq(9'h000);
    pulse_ret();
    pulse_ret();
    $display("nesting test done");
    do_reset();
    sreq(9'h010);
    cyc(3);
    rd(A_ST, 32'h010, "event_status");
    chk("event_irq", 32'h0, event_irq);
    wr(A_EVE, 32'h10);
    cyc(2);
    chk("event_irq", 32'h1, event_irq);
    wr(A_EVE, 32'h0);
    cyc(2);
    chk("event_irq", 32'h0, event_irq);
    wr(A_EVE, 32'h10);
    wr(A_CLR, 32'h10);
    cyc(2);
    chk("event_irq", 32'h0, event_irq);
    rd(A_ST, 32'h0, "event_status");
    $display("event test done");
    end_of_test();
  end
endmodule
`default_nettype wire
